// [inc/sac_defs.svh]
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// Register indices; the byte address is four times the index.
`define SAC_IDX_CSR 8'h2e
`define SAC_IDX_RHI 8'h2f
`define SAC_IDX_RLO 8'h30
`define SAC_IDX_IST 8'h31
`define SAC_IDX_IMK 8'h32

// Control/status field positions.
`define SAC_B_DONE 7
`define SAC_B_DIVH 6
`define SAC_B_DIVL 5
`define SAC_B_ON   4
`define SAC_B_CHH  3

// Reset value of every register.
`define SAC_RST_VAL 8'h00

// Clock rates in MHz and the derived divide ratios.
`define SAC_CLK_MHZ 100
`define SAC_F0_MHZ  4
`define SAC_F1_MHZ  2
`define SAC_F2_MHZ  1
`define SAC_DIV0    (`SAC_CLK_MHZ / `SAC_F0_MHZ)
`define SAC_DIV1    (`SAC_CLK_MHZ / `SAC_F1_MHZ)
`define SAC_DIV2    (`SAC_CLK_MHZ / `SAC_F2_MHZ)

// Sampling length in converter clocks before the bit trials.
`define SAC_SAMPLE_CLKS 3

// First trial code and bus responses.
`define SAC_SAR_MSB  10'h200
`define SAC_RESP_OK  2'b00
`define SAC_RESP_ERR 2'b10

`endif

// [inc/sac_pkg.sv]
package sac_pkg;

  // Converter sequencer states.
  typedef enum logic [1:0] {
    SAC_OFF,
    SAC_SAMPLE,
    SAC_BITS
  } sac_state_t;

endpackage

// [hdl/sac_adc_ctrl.sv]
`timescale 1ns/100ps
`include "sac_defs.svh"

// Overview of operation
// - Converter on starts continuous back-to-back conversions.
// - Clearing converter on aborts and disables.
// - Done flag never rises during conversion.
// - New channel written restarts conversion immediately.
// - Completion sets done flag and interrupt.
// - Results stay unchanged until next completion.
// - Only high byte read clears done.
// - Low byte read freezes both results.
// - High read or converter off unfreezes.
// - Above reference gives high ff, low 03.
// - Below reference gives zero in both.
// - Divider select gives 4, 2, 1 MHz.
// - Four channel bits pick input 0-15.
// - High holds bits 9:2, low 1:0.
// - Done bit read-only; all reset zero.
// - Wait unaffected; halt disables converter.

module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int ADDR_W      = 12,
  parameter int SAMPLE_CLKS = `SAC_SAMPLE_CLKS
) (
  // Clock and reset.
  input  wire logic              ref_clk_in,
  input  wire logic              rst_n_in,
  // Write address and data channels.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  // Write response channel.
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // Read address and data channels.
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // Analog successive approximation core.
  output logic                   adc_power_out,
  output logic                   adc_sample_out,
  output logic [3:0]             adc_channel_out,
  output logic [9:0]             adc_trial_out,
  input  wire logic              adc_cmp_in,
  // System.
  input  wire logic              halt_mode_in,
  output logic                   irq_out
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------

  logic              aw_have_ff, nxt_aw_have;
  logic              w_have_ff,  nxt_w_have;
  logic [ADDR_W-1:0] awaddr_ff,  nxt_awaddr;
  logic [7:0]        wdata_ff,   nxt_wdata;
  logic              wstb_ff,    nxt_wstb;
  logic              awready_ff, nxt_awready;
  logic              wready_ff,  nxt_wready;
  logic              bvalid_ff,  nxt_bvalid;
  logic [1:0]        bresp_ff,   nxt_bresp;
  logic              arready_ff, nxt_arready;
  logic              rvalid_ff,  nxt_rvalid;
  logic [31:0]       rdata_ff,   nxt_rdata;
  logic [1:0]        rresp_ff,   nxt_rresp;
  logic [6:0]        csr_ff,     nxt_csr;

  logic [6:0]        div_cnt_ff, nxt_div_cnt;
  logic              tick_ff,    nxt_tick;
  logic [6:0]        div_top;

  sac_state_t        st_ff,      nxt_st;
  logic [7:0]        samp_ff,    nxt_samp;
  logic [3:0]        bit_ff,     nxt_bit;
  logic [9:0]        sar_ff,     nxt_sar;
  logic              power_ff,   nxt_power;
  logic              sample_ff,  nxt_sample;
  logic [3:0]        chan_ff,    nxt_chan;
  logic              fin;
  logic [9:0]        conv_val;
  logic              run_nxt;
  logic              restart;

  logic [9:0]        res_ff,     nxt_res;
  logic              lock_ff,    nxt_lock;
  logic              done_ff,    nxt_done;
  logic              ist_ff,     nxt_ist;
  logic              imk_ff,     nxt_imk;
  logic              irq_ff,     nxt_irq;

  logic              wr_do;
  logic              wr_csr;
  logic              wr_ist;
  logic              wr_imk;
  logic              rd_go;
  logic              rd_hi;
  logic              rd_lo;
  logic              unlock;
  logic              load;
  logic [7:0]        rd_val;
  logic [7:0]        lo_val;

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------

  // True when a byte address selects the word of a register index.
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        idx);
    hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  // True when a byte address selects any register of the block.
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `SAC_IDX_CSR) || hit(a, `SAC_IDX_RHI) ||
             hit(a, `SAC_IDX_RLO) || hit(a, `SAC_IDX_IST) ||
             hit(a, `SAC_IDX_IMK);
  endfunction

  // Clock divide ratio for a divider select code.
  function automatic logic [6:0] div_len(input logic [1:0] sel);
    unique case (sel)
      2'b00:   div_len = 7'(`SAC_DIV0);
      2'b01:   div_len = 7'(`SAC_DIV1);
      default: div_len = 7'(`SAC_DIV2);
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------------

  // Access strobes derived from the held write and the read handshake.
  assign wr_do  = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_csr = wr_do && wstb_ff && hit(awaddr_ff, `SAC_IDX_CSR);
  assign wr_ist = wr_do && wstb_ff && hit(awaddr_ff, `SAC_IDX_IST);
  assign wr_imk = wr_do && wstb_ff && hit(awaddr_ff, `SAC_IDX_IMK);
  assign rd_go  = s_axi_arvalid_in && arready_ff;
  assign rd_hi  = rd_go && hit(s_axi_araddr_in, `SAC_IDX_RHI);
  assign rd_lo  = rd_go && hit(s_axi_araddr_in, `SAC_IDX_RLO);
  assign lo_val = {6'h00, res_ff[1:0]};

  // Read data selection; reserved and unmapped bits read zero.
  always_comb begin
    rd_val = 8'h00;
    if (hit(s_axi_araddr_in, `SAC_IDX_CSR)) begin
      rd_val = {done_ff, csr_ff};
    end else if (hit(s_axi_araddr_in, `SAC_IDX_RHI)) begin
      rd_val = res_ff[9:2];
    end else if (hit(s_axi_araddr_in, `SAC_IDX_RLO)) begin
      rd_val = lo_val;
    end else if (hit(s_axi_araddr_in, `SAC_IDX_IST)) begin
      rd_val = {7'h00, ist_ff};
    end else if (hit(s_axi_araddr_in, `SAC_IDX_IMK)) begin
      rd_val = {7'h00, imk_ff};
    end
  end

  // Next state of the bus slave and the control register.
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstb    = wstb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    nxt_csr     = csr_ff;
    if (s_axi_awvalid_in && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_awaddr  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_wdata  = s_axi_wdata_in[7:0];
      nxt_wstb   = s_axi_wstrb_in[0];
    end
    if (wr_do) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = mapped(awaddr_ff) ? `SAC_RESP_OK : `SAC_RESP_ERR;
    end
    if (wr_csr) begin
      nxt_csr = wdata_ff[6:0];
    end
    if (bvalid_ff && s_axi_bready_in) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready  = !nxt_w_have && !nxt_bvalid;
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = {24'h000000, rd_val};
      nxt_rresp  = mapped(s_axi_araddr_in) ? `SAC_RESP_OK
                                           : `SAC_RESP_ERR;
    end
    if (rvalid_ff && s_axi_rready_in) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  // Bus slave and control register storage.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_ff <= 1'b0;
      w_have_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 8'h00;
      wstb_ff    <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `SAC_RESP_OK;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h00000000;
      rresp_ff   <= `SAC_RESP_OK;
      csr_ff     <= 7'(`SAC_RST_VAL);
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff  <= nxt_w_have;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstb_ff    <= nxt_wstb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
      csr_ff     <= nxt_csr;
    end
  end

  // ------------------------------------------------------------------
  // Converter clock divider
  // ------------------------------------------------------------------

  // Last count of the divider for the selected rate.
  assign div_top = div_len(csr_ff[`SAC_B_DIVH:`SAC_B_DIVL]) - 7'd1;

  // One-cycle enable at the selected converter rate.
  always_comb begin
    nxt_tick    = 1'b0;
    nxt_div_cnt = div_cnt_ff + 7'd1;
    if (div_cnt_ff >= div_top) begin
      nxt_tick    = 1'b1;
      nxt_div_cnt = 7'd0;
    end
  end

  // Divider storage.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_cnt_ff <= 7'd0;
      tick_ff    <= 1'b0;
    end else begin
      div_cnt_ff <= nxt_div_cnt;
      tick_ff    <= nxt_tick;
    end
  end

  // ------------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------------

  // Run only while switched on and not halted; restart on a new channel.
  assign run_nxt = nxt_csr[`SAC_B_ON] && !halt_mode_in;
  assign restart = run_nxt &&
                   (st_ff == SAC_OFF ||
                    nxt_csr[`SAC_B_CHH:0] != csr_ff[`SAC_B_CHH:0]);

  // Sampling, then one bit trial per converter clock from the top bit.
  always_comb begin
    logic [9:0] b;
    b        = sar_ff;
    nxt_st   = st_ff;
    nxt_samp = samp_ff;
    nxt_bit  = bit_ff;
    nxt_sar  = sar_ff;
    fin      = 1'b0;
    conv_val = sar_ff;
    if (!run_nxt) begin
      nxt_st = SAC_OFF;
    end else if (restart) begin
      nxt_st   = SAC_SAMPLE;
      nxt_samp = 8'd0;
    end else if (tick_ff) begin
      unique case (st_ff)
        SAC_OFF: begin
          nxt_st = SAC_OFF;
        end
        SAC_SAMPLE: begin
          if (samp_ff >= 8'(SAMPLE_CLKS - 1)) begin
            nxt_st  = SAC_BITS;
            nxt_sar = `SAC_SAR_MSB;
            nxt_bit = 4'd9;
          end else begin
            nxt_samp = samp_ff + 8'd1;
          end
        end
        SAC_BITS: begin
          // A missing compare drops the trial bit, so a low input
          // ends at zero and a high input at all ones.
          if (!adc_cmp_in) begin
            b[bit_ff] = 1'b0;
          end
          if (bit_ff == 4'd0) begin
            fin      = 1'b1;
            conv_val = b;
            nxt_st   = SAC_SAMPLE;
            nxt_samp = 8'd0;
          end else begin
            b[bit_ff - 4'd1] = 1'b1;
            nxt_bit = bit_ff - 4'd1;
          end
          nxt_sar = b;
        end
      endcase
    end
    nxt_power  = (nxt_st != SAC_OFF);
    nxt_sample = (nxt_st == SAC_SAMPLE);
    nxt_chan   = nxt_csr[`SAC_B_CHH:0];
  end

  // Sequencer storage.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_ff     <= SAC_OFF;
      samp_ff   <= 8'd0;
      bit_ff    <= 4'd0;
      sar_ff    <= 10'h000;
      power_ff  <= 1'b0;
      sample_ff <= 1'b0;
      chan_ff   <= 4'h0;
    end else begin
      st_ff     <= nxt_st;
      samp_ff   <= nxt_samp;
      bit_ff    <= nxt_bit;
      sar_ff    <= nxt_sar;
      power_ff  <= nxt_power;
      sample_ff <= nxt_sample;
      chan_ff   <= nxt_chan;
    end
  end

  // ------------------------------------------------------------------
  // Results, done flag and interrupt
  // ------------------------------------------------------------------

  // A low byte read locks; a high read or switching off unlocks.
  assign unlock = rd_hi || !nxt_csr[`SAC_B_ON];
  assign load   = fin && (!lock_ff || unlock) && !rd_lo;

  // Flags: a completion in the clearing cycle wins over the clear.
  always_comb begin
    nxt_res  = load ? conv_val : res_ff;
    nxt_lock = lock_ff;
    if (rd_lo) begin
      nxt_lock = 1'b1;
    end else if (unlock) begin
      nxt_lock = 1'b0;
    end
    nxt_done = done_ff;
    if (fin) begin
      nxt_done = 1'b1;
    end else if (rd_hi) begin
      nxt_done = 1'b0;
    end
    nxt_ist = ist_ff;
    if (fin) begin
      nxt_ist = 1'b1;
    end else if (wr_ist && wdata_ff[0]) begin
      nxt_ist = 1'b0;
    end
    nxt_imk = wr_imk ? wdata_ff[0] : imk_ff;
    nxt_irq = nxt_ist && nxt_imk;
  end

  // Result and flag storage.
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      res_ff  <= 10'h000;
      lock_ff <= 1'b0;
      done_ff <= 1'b0;
      ist_ff  <= 1'b0;
      imk_ff  <= 1'b0;
      irq_ff  <= 1'b0;
    end else begin
      res_ff  <= nxt_res;
      lock_ff <= nxt_lock;
      done_ff <= nxt_done;
      ist_ff  <= nxt_ist;
      imk_ff  <= nxt_imk;
      irq_ff  <= nxt_irq;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------

  // Every output is a register.
  assign s_axi_awready_out = awready_ff;
  assign s_axi_wready_out  = wready_ff;
  assign s_axi_bresp_out   = bresp_ff;
  assign s_axi_bvalid_out  = bvalid_ff;
  assign s_axi_arready_out = arready_ff;
  assign s_axi_rdata_out   = rdata_ff;
  assign s_axi_rresp_out   = rresp_ff;
  assign s_axi_rvalid_out  = rvalid_ff;
  assign adc_power_out     = power_ff;
  assign adc_sample_out    = sample_ff;
  assign adc_channel_out   = chan_ff;
  assign adc_trial_out     = sar_ff;
  assign irq_out           = irq_ff;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------

  default clocking sac_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // A completion while still running is followed by a fresh sample.
  sequence s_fin_run;
    fin && run_nxt && !restart;
  endsequence

  // A low byte read followed by the locked state.
  sequence s_lo_locked;
    rd_lo ##1 lock_ff;
  endsequence

  on_start_a: assert property (
    $rose(csr_ff[`SAC_B_ON]) && !$past(halt_mode_in)
      |-> st_ff == SAC_SAMPLE && samp_ff == 8'd0 && adc_power_out)
    else $error("converter did not start sampling");

  cont_conv_a: assert property (
    s_fin_run |=> st_ff == SAC_SAMPLE && adc_sample_out)
    else $error("conversion did not repeat");

  off_stop_a: assert property (
    !csr_ff[`SAC_B_ON] |-> st_ff == SAC_OFF && !adc_power_out)
    else $error("converter runs while switched off");

  done_rise_a: assert property (
    $rose(done_ff) |-> $past(fin))
    else $error("done flag rose without completion");

  chan_restart_a: assert property (
    st_ff == SAC_BITS && run_nxt &&
    nxt_csr[`SAC_B_CHH:0] != csr_ff[`SAC_B_CHH:0]
      |=> st_ff == SAC_SAMPLE && samp_ff == 8'd0 &&
          adc_channel_out == $past(nxt_csr[`SAC_B_CHH:0]))
    else $error("channel change did not restart");

  irq_flag_a: assert property (
    fin |=> done_ff && ist_ff && irq_out == imk_ff)
    else $error("completion flag or interrupt missing");

  res_hold_a: assert property (
    !load |=> $stable(res_ff))
    else $error("result changed without load");

  hi_clear_a: assert property (
    $fell(done_ff) |-> $past(rd_hi))
    else $error("done flag cleared without high read");

  lock_set_a: assert property (
    (rd_lo |=> lock_ff) and
    (s_lo_locked |-> (fin && !unlock |-> !load)))
    else $error("low read did not freeze results");

  unlock_a: assert property (
    lock_ff && unlock && !rd_lo |=> !lock_ff)
    else $error("results stayed frozen");

  full_scale_a: assert property (
    load && conv_val == 10'h3ff
      |=> res_ff[9:2] == 8'hff && lo_val == 8'h03)
    else $error("full scale codes wrong");

  zero_scale_a: assert property (
    load && conv_val == 10'h000
      |=> res_ff[9:2] == 8'h00 && lo_val == 8'h00)
    else $error("zero scale codes wrong");

  ro_done_a: assert property (
    wr_csr && !fin && !rd_hi |=> $stable(done_ff))
    else $error("done bit changed by a write");

  halt_off_a: assert property (
    $past(halt_mode_in) |-> st_ff == SAC_OFF && !adc_power_out)
    else $error("converter runs in halt");

endmodule

// [bench/sac_core_model.sv]
`timescale 1ns/100ps
// ------------------------------------------------------------
// Analog core and input multiplexer model.
// ------------------------------------------------------------
module sac_core_model (
  // Clock.
  input  wire logic        ref_clk_in,
  // Converter controls.
  input  wire logic        power_in,
  input  wire logic        sample_in,
  input  wire logic [3:0]  channel_in,
  input  wire logic [9:0]  trial_in,
  // Input levels, bit 10 set means above the upper reference.
  input  wire logic [10:0] level_in [16],
  // Comparator.
  output logic             cmp_out
);
  logic [10:0] held = 11'h0;
  logic        last = 1'h0;

  // The hold capacitor tracks the selected input while sampling.
  always @(posedge ref_clk_in) begin
    if (sample_in) begin
      held <= level_in[channel_in];
    end
    last <= cmp_out;
  end

  // An unpowered core gives a toggling, useless answer.
  assign cmp_out = power_in ? (held >= {1'h0, trial_in})
                            : ~last;
endmodule

// [bench/sar_adc_control_test.sv]
`timescale 1ns/100ps
`include "sac_defs.svh"
// ------------------------------------------------------------
// Converter control testbench.
// ------------------------------------------------------------
module sar_adc_control_test;
  localparam int SMP = 3;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        halt = 1'h0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        pwr, smp, cmp, irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [3:0]  chan;
  logic [9:0]  trial;
  logic [10:0] level [16];
  int          errors = 0;
  int          n_compared = 0;

  // The 100 MHz clock.
  always #5 clk = ~clk;

  sac_adc_ctrl #(.ADDR_W(12), .SAMPLE_CLKS(SMP)) sac_adc_ctrl_inst (
    .ref_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .adc_power_out(pwr),
    .adc_sample_out(smp), .adc_channel_out(chan),
    .adc_trial_out(trial), .adc_cmp_in(cmp),
    .halt_mode_in(halt), .irq_out(irq));

  sac_core_model sac_core_model_inst (
    .ref_clk_in(clk), .power_in(pwr), .sample_in(smp),
    .channel_in(chan), .trial_in(trial), .level_in(level),
    .cmp_out(cmp));

  // ----------------------------------------------------------
  // Bus and checking tasks.
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Write one register word and hold each channel until taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    rs = bresp;
  endtask

  // Read one register word.
  task automatic rdr(input logic [7:0] idx);
    @(posedge clk);
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd = rdata;
    rs = rresp;
  endtask

  task automatic rdc(input logic [7:0] idx, e, input string nm);
    rdr(idx);
    chk(nm, rd, {24'h0, e});
  endtask

  // Poll the done flag a bounded number of times.
  task automatic wait_done;
    rd = 32'h0;
    for (int i = 0; i < 2000 && rd[7] !== 1'h1; i++) rdr(`SAC_IDX_CSR);
    chk("done", 32'(rd[7]), 32'h1);
  endtask

  // ----------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------
  task automatic t_reset;
    rdc(`SAC_IDX_CSR, 8'h00, "csr");
    rdc(`SAC_IDX_RHI, 8'h00, "rhi");
    rdc(`SAC_IDX_RLO, 8'h00, "rlo");
    rdc(`SAC_IDX_IMK, 8'h00, "imk");
    wr(8'h10, 8'h01);
    chk("wresp", 32'(rs), 32'(`SAC_RESP_ERR));
    rdr(8'h10);
    chk("rresp", 32'(rs), 32'(`SAC_RESP_ERR));
    wr(`SAC_IDX_CSR, 8'h80);
    rdc(`SAC_IDX_CSR, 8'h00, "done ro");
  endtask

  task automatic t_convert;
    level[3] = 11'h2a5;
    wr(`SAC_IDX_IMK, 8'h01);
    wr(`SAC_IDX_CSR, 8'h13);
    chk("chan", 32'(chan), 32'h3);
    rdc(`SAC_IDX_CSR, 8'h13, "busy");
    wait_done;
    chk("irq", 32'(irq), 32'h1);
    rdc(`SAC_IDX_RLO, 8'h01, "lo");
    rdc(`SAC_IDX_RHI, 8'ha9, "hi");
    rdc(`SAC_IDX_CSR, 8'h13, "clr");
    wr(`SAC_IDX_IST, 8'h01);
    rdc(`SAC_IDX_IST, 8'h00, "ist w1c");
    chk("irq off", 32'(irq), 32'h0);
    wait_done;
    wr(`SAC_IDX_IMK, 8'h00);
    rdc(`SAC_IDX_IST, 8'h01, "ist");
    chk("masked", 32'(irq), 32'h0);
    rdc(`SAC_IDX_RHI, 8'ha9, "8 bit");
  endtask

  task automatic t_lock;
    wait_done;
    rdc(`SAC_IDX_RLO, 8'h01, "lock");
    level[3] = 11'h15a;
    repeat (800) @(posedge clk);
    rdc(`SAC_IDX_RHI, 8'ha9, "frozen");
    wait_done;
    rdc(`SAC_IDX_RLO, 8'h02, "new lo");
    rdc(`SAC_IDX_RHI, 8'h56, "new hi");
    rdc(`SAC_IDX_RLO, 8'h02, "relock");
    wr(`SAC_IDX_CSR, 8'h03);
    chk("off", 32'(pwr), 32'h0);
    level[3] = 11'h2a5;
    wr(`SAC_IDX_CSR, 8'h13);
    wait_done;
    rdc(`SAC_IDX_RLO, 8'h01, "off lo");
    rdc(`SAC_IDX_RHI, 8'ha9, "off hi");
  endtask

  task automatic t_sat;
    level[5] = 11'h7ff;
    level[6] = 11'h000;
    // Move into the bit trials so the channel change cuts a conversion.
    repeat (150) @(posedge clk);
    chk("trials", 32'(smp), 32'h0);
    wr(`SAC_IDX_CSR, 8'h15);
    chk("restart", 32'({smp, chan}), 32'h15);
    rdr(`SAC_IDX_RHI);
    wait_done;
    rdc(`SAC_IDX_RLO, 8'h03, "top lo");
    rdc(`SAC_IDX_RHI, 8'hff, "top hi");
    wr(`SAC_IDX_CSR, 8'h16);
    rdr(`SAC_IDX_RHI);
    wait_done;
    rdc(`SAC_IDX_RLO, 8'h00, "bot lo");
    rdc(`SAC_IDX_RHI, 8'h00, "bot hi");
  endtask

  // Conversion period follows the converter clock rate.
  task automatic t_div;
    int  dv [4];
    time t0;
    dv = '{`SAC_DIV0, `SAC_DIV1, `SAC_DIV2, `SAC_DIV2};
    for (int d = 0; d < 4; d++) begin
      wr(`SAC_IDX_CSR, {1'h0, 2'(d), 5'h16});
      @(posedge smp);
      t0 = $time;
      @(posedge smp);
      chk("period", 32'(($time - t0) / 10),
          32'((SMP + 10) * dv[d]));
    end
  endtask

  task automatic t_halt;
    wr(`SAC_IDX_CSR, 8'h13);
    chk("on", 32'(pwr), 32'h1);
    halt <= 1'h1;
    repeat (3) @(posedge clk);
    chk("halt", 32'(pwr), 32'h0);
    halt <= 1'h0;
    repeat (2) @(posedge clk);
    chk("resume", 32'(pwr), 32'h1);
  endtask

  // Watchdog against a hung handshake.
  initial begin
    #1000000;
    errors++;
    give_verdict;
  end

  // Main sequence.
  initial begin
    foreach (level[i]) level[i] = 11'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_reset;
    t_convert;
    t_lock;
    t_sat;
    t_div;
    t_halt;
    give_verdict;
  end
endmodule
